// ===== gpio_function_mux.sv
/*
 * Pin function multiplexer with a classic Wishbone register slave.
 * Assumes a 32-bit Wishbone master, synchronous pin inputs, and that
 * defaults of the selects arrive on cfg_fsel at reset release.
 */
// The Wishbone interface to the registers is this design's own decision.
// Notes on behaviour
// - Select code 0000 connects the pin to plain GPIO, the codes listed below for GPIO0 to GPIO3 to an alternate function.
// - Direction 1 picks the input-column function, direction 0 the output-column one.
// - Reading the GPIO interrupt status at 1Eh clears its pending events.
// - After a nonzero status read, software reads 18h, which releases the interrupt request pin.
// - In 3-wire and 4-wire mode GPIO7 is forced to be the serial chip-select input.
// - In 4-wire mode GPIO6 is forced to be the serial data output.
// - Select fields are four bits, four per register at 8Ch to 8Eh, GPIO12 in 8Fh bits 3:0.
// - GPIO0 codes map to power-on, regulator, low-power 1/reset indicator, power-off/reset, chip reset.
// - GPIO1 codes map to power-on/config indicator, regulator/reset, low-power 2/memory reset, request_a/slow clock.
// - GPIO2 codes map to power-on, request_a/backup regulator, slow clock, low-power 3/reset.
// - GPIO3 codes map to power-on/phase clock, regulator/backup, power-off/slow clock, flash/memory reset.
`timescale 1ns/1ps
module gpio_function_mux #(
	parameter int NP = pin_mux_pkg::NPINS
) (
	input  wire logic                         clk,
	input  wire logic                         nrst,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [pin_mux_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// Configuration defaults and event sources
	input  wire logic [NP*4-1:0]              cfg_fsel,
	input  wire logic [NP-1:0]                gpio_event,
	output logic                              irq_n,
	// Pads
	input  wire logic [NP-1:0]                pad_in,
	output logic      [NP-1:0]                pad_out,
	output logic      [NP-1:0]                pad_oe,
	// Serial control interface
	input  wire logic                         serial_data_output,
	output logic                              serial_chip_select,
	// Alternate inputs sampled from pins
	output logic                              power_on_signal,
	output logic                              regulator_disable_input,
	output logic [2:0]                        low_power_request,
	output logic                              power_off_request,
	output logic                              chip_reset_req,
	output logic                              request_a,
	output logic                              slow_clock_in,
	output logic                              flash_trigger,
	// Alternate output sources
	input  wire logic                         power_on_src,
	input  wire logic                         backup_regulator_output,
	input  wire logic                         por_indicator,
	input  wire logic                         sys_reset_n,
	input  wire logic                         dev_config_indicator,
	input  wire logic                         memory_reset_output,
	input  wire logic                         slow_clock,
	input  wire logic                         phase_clock
);
	import pin_mux_pkg::*;

	// ============================================================
	// Registers
	logic [FN_W-1:0] fsel_q [NP];
	logic [NP-1:0]   dir_q;
	logic [NP-1:0]   gout_q;
	logic [1:0]      mode_q;
	logic [NP-1:0]   gpio_sts_q;
	logic            sys_gpio_q;
	logic            cfg_load_q;
	logic [7:0]      idx;
	logic            acc;
	logic            wr;
	logic            rd;

	assign idx = wb_adr_i[ADDR_W-1:2];
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i; // Lands at the edge where ack is seen
	assign rd  = acc && !wb_we_i;

	// Register index to select-field base, -1 when not a select register
	function automatic int fsel_base(input logic [7:0] i);
		if (i >= IDX_FSEL_A && i <= IDX_FSEL_D)
			return int'(i - IDX_FSEL_A) * FN_PER_R;
		return -1;
	endfunction

	// One-cycle answer; ack drops the cycle after it is given
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= acc;
	end

	// One-shot load of configured defaults after reset release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cfg_load_q <= 1'b1;
		else
			cfg_load_q <= 1'b0;
	end

	// Select fields; byte lanes 0 and 1 cover a 16-bit register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NP; p++)
				fsel_q[p] <= FN_GPIO;
		end else if (cfg_load_q) begin
			for (int p = 0; p < NP; p++)
				fsel_q[p] <= cfg_fsel[p*FN_W +: FN_W];
		end else if (wr && fsel_base(idx) >= 0) begin
			for (int f = 0; f < FN_PER_R; f++) begin
				if (fsel_base(idx) + f < NP && wb_sel_i[f/2])
					fsel_q[fsel_base(idx) + f] <= wb_dat_i[f*FN_W +: FN_W];
			end
		end
	end

	// Direction, GPIO output data and control mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_q  <= '1;
			gout_q <= '0;
			mode_q <= 2'(MODE_2WIRE);
		end else if (wr) begin
			if (idx == IDX_DIR && wb_sel_i[0])
				dir_q[7:0] <= wb_dat_i[7:0];
			if (idx == IDX_DIR && wb_sel_i[1])
				dir_q[NP-1:8] <= wb_dat_i[NP-1:8];
			if (idx == IDX_GPIO_OUT && wb_sel_i[0])
				gout_q[7:0] <= wb_dat_i[7:0];
			if (idx == IDX_GPIO_OUT && wb_sel_i[1])
				gout_q[NP-1:8] <= wb_dat_i[NP-1:8];
			if (idx == IDX_CTRL_MODE && wb_sel_i[0])
				mode_q <= wb_dat_i[1:0];
		end
	end

	// status read clears; a new event in the same cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			gpio_sts_q <= '0;
		else if (rd && idx == IDX_GPIO_IRQ)
			gpio_sts_q <= gpio_event;
		else
			gpio_sts_q <= gpio_sts_q | gpio_event;
	end

	// system summary bit released by a read of 18h
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sys_gpio_q <= 1'b0;
		else if (|gpio_sts_q || |gpio_event)
			sys_gpio_q <= 1'b1;
		else if (rd && idx == IDX_SYS_IRQ)
			sys_gpio_q <= 1'b0;
	end
	assign irq_n = !sys_gpio_q;

	// Read data registered with the ack; unmapped reads return zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= '0;
		end else if (rd) begin
			wb_dat_o <= '0;
			if (fsel_base(idx) >= 0) begin
				for (int f = 0; f < FN_PER_R; f++)
					if (fsel_base(idx) + f < NP)
						wb_dat_o[f*FN_W +: FN_W] <= fsel_q[fsel_base(idx) + f];
			end
			case (idx)
				IDX_DIR:       wb_dat_o[NP-1:0] <= dir_q;
				IDX_GPIO_OUT:  wb_dat_o[NP-1:0] <= gout_q;
				IDX_GPIO_IN:   wb_dat_o[NP-1:0] <= pad_in;
				IDX_CTRL_MODE: wb_dat_o[1:0]    <= mode_q;
				IDX_GPIO_IRQ:  wb_dat_o[NP-1:0] <= gpio_sts_q;
				IDX_SYS_IRQ:   wb_dat_o[0]      <= sys_gpio_q;
				default:       ;
			endcase
		end
	end

	// ============================================================
	// Pin routing
	logic force_cs;
	logic force_sdo;
	assign force_cs  = (mode_q == 2'(MODE_3WIRE)) || (mode_q == 2'(MODE_4WIRE));
	assign force_sdo = (mode_q == 2'(MODE_4WIRE));

	// Input-column selection helper
	function automatic logic in_sel(input int p, input logic [3:0] code,
		input logic [NP-1:0] d, input logic [FN_W-1:0] f [NP], input logic [NP-1:0] pin);
		return d[p] && f[p] == code && pin[p];
	endfunction

	// input-column decoding, sources of a function on several pins ORed together
	always_comb begin
		chip_reset_req = in_sel(0, FN_C5, dir_q, fsel_q, pad_in);
		request_a = in_sel(1, FN_C4, dir_q, fsel_q, pad_in)
			| in_sel(2, FN_C2, dir_q, fsel_q, pad_in);
		power_on_signal = in_sel(0, FN_C1, dir_q, fsel_q, pad_in) | in_sel(1, FN_C1, dir_q, fsel_q, pad_in)
			| in_sel(2, FN_C1, dir_q, fsel_q, pad_in) | in_sel(3, FN_C1, dir_q, fsel_q, pad_in);
		regulator_disable_input = in_sel(0, FN_C2, dir_q, fsel_q, pad_in)
			| in_sel(1, FN_C2, dir_q, fsel_q, pad_in) | in_sel(3, FN_C2, dir_q, fsel_q, pad_in);
		low_power_request[0] = in_sel(0, FN_C3, dir_q, fsel_q, pad_in);
		low_power_request[1] = in_sel(1, FN_C3, dir_q, fsel_q, pad_in);
		low_power_request[2] = in_sel(2, FN_C4, dir_q, fsel_q, pad_in);
		power_off_request = in_sel(0, FN_C4, dir_q, fsel_q, pad_in) | in_sel(3, FN_C3, dir_q, fsel_q, pad_in);
		slow_clock_in = in_sel(2, FN_C3, dir_q, fsel_q, pad_in);
		flash_trigger = in_sel(3, FN_C4, dir_q, fsel_q, pad_in);
		serial_chip_select = force_cs ? pad_in[CS_PIN] : 1'b1;
	end

	// output-column decoding, 0000 is plain GPIO
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			pad_oe[p]  = !dir_q[p];
			pad_out[p] = (fsel_q[p] == FN_GPIO) ? gout_q[p] : 1'b0;
		end
		if (!dir_q[0]) begin
			case (fsel_q[0])
				FN_C1:   pad_out[0] = power_on_src;
				FN_C2:   pad_out[0] = backup_regulator_output;
				FN_C3:   pad_out[0] = por_indicator;
				FN_C4:   pad_out[0] = sys_reset_n;
				default: ;
			endcase
		end
		if (!dir_q[1]) begin
			case (fsel_q[1])
				FN_C1:   pad_out[1] = dev_config_indicator;
				FN_C2:   pad_out[1] = sys_reset_n;
				FN_C3:   pad_out[1] = memory_reset_output;
				FN_C4:   pad_out[1] = slow_clock;
				default: ;
			endcase
		end
		if (!dir_q[2]) begin
			case (fsel_q[2])
				FN_C1:   pad_out[2] = power_on_src;
				FN_C2:   pad_out[2] = backup_regulator_output;
				FN_C3:   pad_out[2] = slow_clock;
				FN_C4:   pad_out[2] = sys_reset_n;
				default: ;
			endcase
		end
		if (!dir_q[3]) begin
			case (fsel_q[3])
				FN_C1:   pad_out[3] = phase_clock;
				FN_C2:   pad_out[3] = backup_regulator_output;
				FN_C3:   pad_out[3] = slow_clock;
				FN_C4:   pad_out[3] = memory_reset_output;
				default: ;
			endcase
		end
		// chip-select pin is an input whatever its fields say
		if (force_cs) begin
			pad_oe[CS_PIN]  = 1'b0;
			pad_out[CS_PIN] = 1'b0;
		end
		// data-out pin driven by the serial interface
		if (force_sdo) begin
			pad_oe[SDO_PIN]  = 1'b1;
			pad_out[SDO_PIN] = serial_data_output;
		end
	end

	// ============================================================
	// Checks
	// status read empties
	sts_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		rd && idx == IDX_GPIO_IRQ && gpio_event == '0 |=> gpio_sts_q == '0)
		else $error("status not cleared by read");
	irq_release_a: assert property (@(posedge clk) disable iff (!nrst)
		rd && idx == IDX_SYS_IRQ && gpio_sts_q == '0 && gpio_event == '0 |=> irq_n)
		else $error("irq not released");
	cs_force_a: assert property (@(posedge clk) disable iff (!nrst)
		force_cs |-> !pad_oe[CS_PIN] && serial_chip_select == pad_in[CS_PIN])
		else $error("chip select not forced");
	sdo_force_a: assert property (@(posedge clk) disable iff (!nrst)
		force_sdo |-> pad_oe[SDO_PIN] && pad_out[SDO_PIN] == serial_data_output)
		else $error("data out not forced");
	gpio_plain_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[0] == FN_GPIO && !dir_q[0] |-> pad_out[0] == gout_q[0])
		else $error("gpio output wrong");
	dir_column_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[3] == FN_C4 && dir_q[3] |-> flash_trigger == pad_in[3] && !pad_oe[3])
		else $error("input column wrong");
	fsel_write_a: assert property (@(posedge clk) disable iff (!nrst)
		wr && idx == IDX_FSEL_A && wb_sel_i[1] && !cfg_load_q |=> fsel_q[3] == $past(wb_dat_i[15:12]))
		else $error("select write lost");
	gp0_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[0] == FN_C4 && !dir_q[0] |-> pad_out[0] == sys_reset_n)
		else $error("gpio0 route wrong");
	gp1_clock_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[1] == FN_C4 && !dir_q[1] |-> pad_out[1] == slow_clock)
		else $error("gpio1 route wrong");
	gp2_vreg_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[2] == FN_C2 && !dir_q[2] |-> pad_out[2] == backup_regulator_output)
		else $error("gpio2 route wrong");
	gp3_phase_a: assert property (@(posedge clk) disable iff (!nrst)
		fsel_q[3] == FN_C1 && !dir_q[3] |-> pad_out[3] == phase_clock)
		else $error("gpio3 route wrong");
	cfg_load_a: assert property (@(posedge clk) disable iff (!nrst)
		cfg_load_q |=> fsel_q[0] == $past(cfg_fsel[3:0]))
		else $error("defaults not loaded");
	ack_one_c:  cover property (@(posedge clk) disable iff (!nrst) acc && wb_we_i ##1 wr);
	irq_seq_c:  cover property (@(posedge clk) disable iff (!nrst) !irq_n ##[1:20] irq_n);
	mode4_c:    cover property (@(posedge clk) disable iff (!nrst) force_sdo);
endmodule // gpio_function_mux

// ===== host_model.sv
/*
 * Host software model: classic Wishbone master with register tasks.
 * Assumes a registered one-cycle ack and the word index in adr[9:2].
 */
`timescale 1ns/1ps
module host_model (
	input  wire logic                           clk,
	output logic                                cyc,
	output logic                                stb,
	output logic                                we,
	output logic [pin_mux_pkg::ADDR_W-1:0]      adr,
	output logic [3:0]                          sel,
	output logic [31:0]                         dat_w,
	input  wire logic                           ack,
	input  wire logic [31:0]                    dat_r
);
	import pin_mux_pkg::*;
	// ============================================================
	// Bus idle at time zero
	initial begin
		cyc   = 1'b0;
		stb   = 1'b0;
		we    = 1'b0;
		adr   = '0;
		sel   = 4'h0;
		dat_w = 32'h0000_0000;
	end
	// ============================================================
	// One classic cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc   <= 1'b1;
		stb   <= 1'b1;
		we    <= w;
		adr   <= {idx, 2'b00};
		sel   <= 4'h3;
		dat_w <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_r; // Data taken at the ack edge only
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] q);
		xfer(1'b0, idx, 16'h0000, q);
	endtask
	// ============================================================
	// Pin reassignment, safe order to avoid glitching functions
	// select cleared first
	task automatic reassign(input logic [7:0] fidx, input logic [15:0] dir, input logic [15:0] fval);
		wr(fidx, 16'h0000);
		wr(IDX_DIR, dir);
		wr(fidx, fval);
	endtask
	task automatic clear_irq(output logic [31:0] st);
		logic [31:0] q;
		rd(IDX_GPIO_IRQ, st);
		if (st !== 32'h0000_0000) rd(IDX_SYS_IRQ, q);
	endtask
endmodule // host_model

// ===== pin_mux_pkg.sv
/*
 * Constants for the pin function multiplexer: register indices, field
 * layout, function codes and the interrupt-status addresses.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package pin_mux_pkg;
	// ============================================================
	// Register map (word indices; byte address is index times four)
	localparam logic [7:0] IDX_FSEL_A      = 8'h8C;
	localparam logic [7:0] IDX_FSEL_B      = 8'h8D;
	localparam logic [7:0] IDX_FSEL_C      = 8'h8E;
	localparam logic [7:0] IDX_FSEL_D      = 8'h8F;
	localparam logic [7:0] IDX_SYS_IRQ     = 8'h18;
	localparam logic [7:0] IDX_GPIO_IRQ    = 8'h1E;
	localparam logic [7:0] IDX_DIR         = 8'h90;
	localparam logic [7:0] IDX_CTRL_MODE   = 8'h91;
	localparam logic [7:0] IDX_GPIO_OUT    = 8'h92;
	localparam logic [7:0] IDX_GPIO_IN     = 8'h93;
	// ============================================================
	// Geometry
	localparam int NPINS    = 13;
	localparam int FN_W     = 4;
	localparam int FN_PER_R = 4;
	localparam int ADDR_W   = 10;
	localparam int CS_PIN   = 7;
	localparam int SDO_PIN  = 6;
	// ============================================================
	// Function codes
	localparam logic [3:0] FN_GPIO = 4'h0;
	localparam logic [3:0] FN_C1   = 4'h1;
	localparam logic [3:0] FN_C2   = 4'h2;
	localparam logic [3:0] FN_C3   = 4'h3;
	localparam logic [3:0] FN_C4   = 4'h4;
	localparam logic [3:0] FN_C5   = 4'h5;
	// ============================================================
	// Control-interface modes
	typedef enum logic [1:0] {
		MODE_2WIRE,
		MODE_3WIRE,
		MODE_4WIRE,
		MODE_RSVD
	} ctrl_mode_e;
endpackage

// ===== testbench.sv
/*
 * Self-checking bench for the pin function multiplexer.
 * Assumes host_model for bus access and a 125 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
	import pin_mux_pkg::*;
	logic clk, nrst, cyc, stb, we, ack, irq_n, sdo, cs;
	logic [ADDR_W-1:0] adr;
	logic [3:0]        sel;
	logic [31:0]       dw, dr, q;
	logic [51:0]       cfg;
	logic [12:0]       ev, pad_in, pad_out, pad_oe;
	logic [7:0]        src;
	logic [9:0]        ins;
	logic [15:0]       e, fv;
	int                checks, n_mismatch;
	// Entries: pin, code, input index, output source index (F = none)
	localparam logic [15:0] TBL [17] = '{16'h0100, 16'h0211, 16'h0322, 16'h0453, 16'h056F,
		16'h1104, 16'h1213, 16'h1335, 16'h1476, 16'h2100, 16'h2271, 16'h2386, 16'h2443,
		16'h3107, 16'h3211, 16'h3356, 16'h3495};
	// ============================================================
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	host_model host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dw),
		.ack(ack), .dat_r(dr));
	gpio_function_mux dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .cfg_fsel(cfg),
		.gpio_event(ev), .irq_n(irq_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.serial_data_output(sdo), .serial_chip_select(cs), .power_on_signal(ins[0]),
		.regulator_disable_input(ins[1]), .low_power_request(ins[4:2]), .power_off_request(ins[5]),
		.chip_reset_req(ins[6]), .request_a(ins[7]), .slow_clock_in(ins[8]), .flash_trigger(ins[9]),
		.power_on_src(src[0]), .backup_regulator_output(src[1]), .por_indicator(src[2]),
		.sys_reset_n(src[3]), .dev_config_indicator(src[4]), .memory_reset_output(src[5]),
		.slow_clock(src[6]), .phase_clock(src[7]));
	// ============================================================
	// Compare and report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog, far beyond the expected several hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("Error watchdog expected finish seen timeout");
		summarize();
	end
	// ============================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		cfg = 52'h5_4321_A987_1234;
		ev = '0;
		pad_in = '0;
		sdo = 1'b0;
		src = 8'h00;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		host.rd(IDX_FSEL_A, q); chk("fsel_a default", 32'h1234, q);
		host.rd(IDX_FSEL_B, q); chk("fsel_b default", 32'hA987, q);
		host.rd(IDX_FSEL_C, q); chk("fsel_c default", 32'h4321, q);
		host.rd(IDX_FSEL_D, q); chk("fsel_d default", 32'h0005, q);
		host.wr(IDX_FSEL_D, 16'hFFFF);
		host.rd(IDX_FSEL_D, q); chk("fsel_d width", 32'h000F, q);
		host.wr(IDX_FSEL_B, 16'h5A3C);
		host.rd(IDX_FSEL_B, q); chk("fsel_b rw", 32'h5A3C, q);
		host.wr(8'hFF, 16'hFFFF);
		host.rd(8'hFF, q); chk("unmapped", 32'h0, q);
		host.reassign(IDX_FSEL_A, 16'h1FFE, 16'h0000);
		host.wr(IDX_GPIO_OUT, 16'h0001);
		@(negedge clk);
		chk("gpio0 oe", 1'b1, pad_oe[0]);
		chk("gpio0 out", 1'b1, pad_out[0]);
		host.reassign(IDX_FSEL_A, 16'h1FFF, 16'h0000);
		@(posedge clk); pad_in <= 13'h0001;
		host.rd(IDX_GPIO_IN, q); chk("gpio0 in", 32'h0001, q);
		@(posedge clk); pad_in <= '0;
		// each listed code in the input column, and in the output column unless its source is F
		for (int i = 0; i < 17; i++) begin
			e = TBL[i];
			fv = {12'h000, e[11:8]} << (4 * e[15:12]);
			host.reassign(IDX_FSEL_A, 16'h1FFF, fv);
			@(posedge clk); pad_in <= 13'h0001 << e[15:12];
			@(negedge clk); chk("alt input", 32'h1 << e[7:4], ins);
			@(posedge clk); pad_in <= '0;
			if (e[3:0] != 4'hF) begin
				host.reassign(IDX_FSEL_A, 16'h1FFF & ~(16'h0001 << e[15:12]), fv);
				@(posedge clk); src <= 8'h01 << e[3:0];
				// Input column must stay quiet while the pin drives
				pad_in <= 13'h0001 << e[15:12];
				@(negedge clk); chk("alt out high", 1'b1, pad_out[e[15:12]]);
				chk("alt oe", 1'b1, pad_oe[e[15:12]]);
				chk("alt in off", 32'h0, ins);
				@(posedge clk); src <= ~(8'h01 << e[3:0]);
				pad_in <= '0;
				@(negedge clk); chk("alt out low", 1'b0, pad_out[e[15:12]]);
			end
		end
		host.reassign(IDX_FSEL_B, 16'h1F7F, 16'h0000);
		host.wr(IDX_CTRL_MODE, 16'h0001);
		@(negedge clk);
		chk("cs oe 3w", 1'b0, pad_oe[7]);
		chk("cs low 3w", 1'b0, cs);
		chk("sdo oe 3w", 1'b0, pad_oe[6]);
		// data output forced in 4-wire mode
		host.wr(IDX_CTRL_MODE, 16'h0002);
		@(posedge clk); pad_in <= 13'h0080; sdo <= 1'b1;
		@(negedge clk);
		chk("sdo oe 4w", 1'b1, pad_oe[6]);
		chk("sdo high", 1'b1, pad_out[6]);
		chk("cs high 4w", 1'b1, cs);
		@(posedge clk); sdo <= 1'b0;
		@(negedge clk); chk("sdo low", 1'b0, pad_out[6]);
		host.wr(IDX_CTRL_MODE, 16'h0000);
		@(posedge clk); pad_in <= '0;
		@(negedge clk);
		chk("cs idle 2w", 1'b1, cs);
		chk("gpio7 oe 2w", 1'b1, pad_oe[7]);
		chk("gpio6 oe 2w", 1'b0, pad_oe[6]);
		@(posedge clk); ev <= 13'h0004;
		@(posedge clk); ev <= '0;
		repeat (2) @(negedge clk);
		chk("irq_n raised", 1'b0, irq_n);
		host.clear_irq(q); chk("gpio status", 32'h0004, q);
		@(negedge clk); chk("irq_n released", 1'b1, irq_n);
		host.rd(IDX_GPIO_IRQ, q); chk("status cleared", 32'h0, q);
		summarize();
	end
endmodule // testbench
